// file: rtl/autoneg_next_page_tx_reg.sv
/*
 Next page transmit register: software-written contents of the next page
 link code word, with the alternation flag kept by the device.
 Assumes the auto-negotiation arbiter runs on core_clk and pulses
 base_page_sent and np_word_sent once per transmitted code word.
*/
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "autoneg_np_defines.svh"

module autoneg_next_page_tx_reg
	import autoneg_np_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        partner_np_able,
	input  wire logic        base_page_sent,
	input  wire logic        base_toggle_bit,
	input  wire logic        np_word_sent,
	output logic             np_send,
	output np_word_t         np_word
);

	logic        more_pages;
	logic        message_page;
	logic        comply_ack;
	logic        toggle;
	logic [10:0] code;
	logic        after_base;
	logic        wr_hit;

	// Reset image kept as a vector so single fields can be sliced from it
	localparam logic [15:0] reset_word = `NPT_RESET;

	function automatic logic addr_hit(input logic [4:0] a);
		addr_hit = (a == `NPT_ADDR);
	endfunction

	// Register image as software sees it; the reserved bit is forced low
	function automatic np_word_t pack_image(
		input logic        mp,
		input logic        pt,
		input logic        ack,
		input logic        tg,
		input logic [10:0] cd
	);
		pack_image = '{mp, 1'b0, pt, ack, tg, cd};
	endfunction

	assign wr_hit = reg_wr && addr_hit(reg_addr);

	// Only the read-write fields take write data; toggle and reserved are kept
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			more_pages   <= reset_word[`NPT_BIT_MORE];
			message_page <= reset_word[`NPT_BIT_MSG];
			comply_ack   <= reset_word[`NPT_BIT_COMPLY_ACK_FLAG];
			code         <= reset_word[`NPT_CODE_MSB:0];
		end
		else if (wr_hit)
		begin
			more_pages   <= reg_wdata[`NPT_BIT_MORE];
			message_page <= reg_wdata[`NPT_BIT_MSG];
			comply_ack   <= reg_wdata[`NPT_BIT_COMPLY_ACK_FLAG];
			code         <= reg_wdata[`NPT_CODE_MSB:0];
		end
	end

	// A base page restarts the sequence, so it wins over a word in the same cycle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			toggle <= 1'b0;
		else if (base_page_sent)
			toggle <= ~base_toggle_bit;
		else if (np_word_sent)
			toggle <= ~toggle;
	end

	// Next page phase opens after the base word and closes with the last page
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			after_base <= 1'b0;
		else if (base_page_sent)
			after_base <= 1'b1;
		else if (np_word_sent && !np_word.more_pages_flag)
			after_base <= 1'b0;
	end

	assign np_send = after_base && partner_np_able && more_pages;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			np_word <= reset_word;
		else
		begin
			np_word.more_pages_flag   <= wr_hit ? reg_wdata[`NPT_BIT_MORE] : more_pages;
			np_word.reserved          <= 1'b0;
			np_word.message_page_flag <= wr_hit ? reg_wdata[`NPT_BIT_MSG] : message_page;
			np_word.comply_ack_flag   <= wr_hit ? reg_wdata[`NPT_BIT_COMPLY_ACK_FLAG] : comply_ack;
			np_word.toggle            <= base_page_sent ? ~base_toggle_bit :
			                             np_word_sent ? ~toggle : toggle;
			np_word.code              <= wr_hit ? reg_wdata[`NPT_CODE_MSB:0] : code;
		end
	end

	// Unmapped addresses and idle cycles read as zero
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 16'h0000;
		else if (reg_rd && addr_hit(reg_addr))
			reg_rdata <= pack_image(more_pages, message_page, comply_ack, toggle, code);
		else
			reg_rdata <= 16'h0000;
	end

	chk_more_pages_copy:
		assert property (@(posedge core_clk) disable iff (!rstn)
			wr_hit |=> np_word.more_pages_flag == $past(reg_wdata[15]))
		else $error("more pages flag not copied");

	chk_last_page_end:
		assert property (@(posedge core_clk) disable iff (!rstn)
			np_word_sent && !base_page_sent && !np_word.more_pages_flag |=> !after_base)
		else $error("phase open after last page");

	chk_send_gate:
		assert property (@(posedge core_clk) disable iff (!rstn)
			np_send |-> partner_np_able && more_pages && after_base)
		else $error("next page sent without permission");

	chk_base_opens:
		assert property (@(posedge core_clk) disable iff (!rstn)
			base_page_sent ##1 (partner_np_able && more_pages) |-> np_send)
		else $error("next pages not enabled after base");

	chk_reserved_zero:
		assert property (@(posedge core_clk) disable iff (!rstn)
			reg_rd |=> reg_rdata[14] == 1'b0 && np_word.reserved == 1'b0)
		else $error("reserved bit not zero");

	chk_page_type:
		assert property (@(posedge core_clk) disable iff (!rstn)
			wr_hit |=> np_word.message_page_flag == $past(reg_wdata[13]))
		else $error("page type not copied");

	chk_comply_copy:
		assert property (@(posedge core_clk) disable iff (!rstn)
			wr_hit |=> np_word.comply_ack_flag == $past(reg_wdata[12]))
		else $error("comply flag not copied");

	chk_toggle_flip:
		assert property (@(posedge core_clk) disable iff (!rstn)
			np_word_sent && !base_page_sent |=> toggle != $past(toggle) && np_word.toggle == toggle)
		else $error("toggle did not invert");

	chk_toggle_start:
		assert property (@(posedge core_clk) disable iff (!rstn)
			base_page_sent |=> toggle == !$past(base_toggle_bit))
		else $error("first toggle not inverse of base");

	chk_code_copy:
		assert property (@(posedge core_clk) disable iff (!rstn)
			wr_hit |=> np_word.code == $past(reg_wdata[10:0]))
		else $error("code field not copied");

	chk_read_back:
		assert property (@(posedge core_clk) disable iff (!rstn)
			reg_rd && reg_addr == 5'h07 |=>
				reg_rdata == {$past(more_pages), 1'b0, $past(message_page),
				$past(comply_ack), $past(toggle), $past(code)})
		else $error("read data wrong");

	chk_unmapped_zero:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!(reg_rd && reg_addr == 5'h07) |=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");

	chk_ro_ignored:
		assert property (@(posedge core_clk) disable iff (!rstn)
			wr_hit && !base_page_sent && !np_word_sent |=> toggle == $past(toggle))
		else $error("write changed toggle");

	chk_reset_image:
		assert property (@(posedge core_clk)
			$rose(rstn) |->
				np_word == reset_word && toggle == 1'b0 && !after_base)
		else $error("reset image wrong");

	chk_word_more_sync:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!wr_hit |=>
				np_word.more_pages_flag == more_pages)
		else $error("word more pages flag differs");

	chk_word_type_sync:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!wr_hit |=>
				np_word.message_page_flag == message_page)
		else $error("word page type differs");

	chk_word_ack_sync:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!wr_hit |=>
				np_word.comply_ack_flag == comply_ack)
		else $error("word comply flag differs");

	chk_word_code_sync:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!wr_hit |=>
				np_word.code == code)
		else $error("word code differs");

	chk_word_toggle_sync:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!base_page_sent && !np_word_sent |=>
				np_word.toggle == toggle)
		else $error("word toggle differs");

	chk_toggle_hold:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!base_page_sent && !np_word_sent |=>
				toggle == $past(toggle))
		else $error("toggle moved without a word");

	chk_base_wins:
		assert property (@(posedge core_clk) disable iff (!rstn)
			base_page_sent && np_word_sent |=>
				toggle == !$past(base_toggle_bit))
		else $error("base page did not win");

	chk_rw_hold:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!wr_hit |=>
				more_pages == $past(more_pages) && code == $past(code))
		else $error("field changed without write");

	chk_fields_hold:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!wr_hit |=>
				message_page == $past(message_page) && comply_ack == $past(comply_ack))
		else $error("flag changed without write");

	chk_rsvd_write:
		assert property (@(posedge core_clk) disable iff (!rstn)
			wr_hit |=>
				np_word.reserved == 1'b0)
		else $error("write reached reserved bit");

	chk_rsvd_bus:
		assert property (@(posedge core_clk) disable iff (!rstn)
			reg_rd && addr_hit(reg_addr) |=>
				reg_rdata[`NPT_BIT_RSVD] == 1'b0)
		else $error("reserved bit read as one");

	chk_phase_base:
		assert property (@(posedge core_clk) disable iff (!rstn)
			base_page_sent |=>
				after_base)
		else $error("base page did not open phase");

	chk_phase_hold:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!base_page_sent && !np_word_sent |=>
				after_base == $past(after_base))
		else $error("phase changed without event");

	chk_last_stops:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!more_pages |->
				!np_send)
		else $error("send with last page flag");

	chk_able_needed:
		assert property (@(posedge core_clk) disable iff (!rstn)
			!partner_np_able || !after_base |->
				!np_send)
		else $error("send without partner or phase");

endmodule

// file: shared/autoneg_np_defines.svh
/*
 Constants of the next page transmit register: address, field positions,
 reset value. Assumes a 5-bit management address space and 16-bit words.
*/
`ifndef AUTONEG_NP_DEFINES_SVH
`define AUTONEG_NP_DEFINES_SVH

`define NPT_ADDR          5'h07
`define NPT_BIT_MORE      4'hF
`define NPT_BIT_RSVD      4'hE
`define NPT_BIT_MSG       4'hD
`define NPT_BIT_COMPLY_ACK_FLAG      4'hC
`define NPT_BIT_TOGGLE    4'hB
`define NPT_CODE_MSB      4'hA
`define NPT_RESET         16'h2001
`define NPT_RW_MASK       16'hB7FF

`endif

// file: shared/autoneg_np_pkg.sv
/*
 Types of the next page transmit register block.
 Assumes the constants header is included by its users.
*/
package autoneg_np_pkg;

	typedef struct packed
	{
		logic        more_pages_flag;
		logic        reserved;
		logic        message_page_flag;
		logic        comply_ack_flag;
		logic        toggle;
		logic [10:0] code;
	} np_word_t;

endpackage

// file: tb/link_partner_model.sv
/* Link-side partner: base page and next page word pulses.
 Assumes one core_clk domain and one-cycle pulses. */
`timescale 1ns/1ns
module link_partner_model
(
	input  wire logic core_clk,
	output logic      partner_np_able = 1'b0,
	output logic      base_page_sent = 1'b0,
	output logic      base_toggle_bit = 1'b0,
	output logic      np_word_sent = 1'b0
);
	// One code word per call; the bit line takes the inverse of bit11 once the pulse ends
	task automatic pulse(input logic base, input logic bit11, input logic able);
		@(posedge core_clk);
		partner_np_able <= able;
		base_page_sent <= base;
		np_word_sent <= ~base;
		base_toggle_bit <= bit11;
		@(posedge core_clk);
		base_page_sent <= 1'b0;
		np_word_sent <= 1'b0;
		base_toggle_bit <= ~bit11;
		#1;
	endtask
endmodule

// file: tb/tb_autoneg_next_page_tx_reg.sv
/* Bench of the next page transmit register: write/read rows, then unmapped,
 toggle and reset cases. Assumes the partner model drives the link pulses. */
`timescale 1ns/1ns
`include "autoneg_np_defines.svh"
module tb_autoneg_next_page_tx_reg
	import autoneg_np_pkg::*;
;
	logic        core_clk, rstn, reg_wr, reg_rd;
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rd_val;
	logic        partner_np_able, base_page_sent, base_toggle_bit, np_word_sent, np_send;
	np_word_t    np_word;
	int          n_fail, samples_checked;
	// Written value above, expected value below; bits 14 and 11 never take a write
	logic [31:0] rows [5] = '{32'h2001_2001, 32'hFFFF_B7FF, 32'h0000_0000, 32'h5800_1000, 32'h87FF_87FF};

	autoneg_next_page_tx_reg autoneg_next_page_tx_reg_inst (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .partner_np_able, .base_page_sent, .base_toggle_bit, .np_word_sent, .np_send, .np_word);
	link_partner_model link_partner_model_inst (.core_clk, .partner_np_able, .base_page_sent, .base_toggle_bit,
		.np_word_sent);

	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d & ~(16'h0001 << `NPT_BIT_RSVD);
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask

	task automatic tally_and_finish;
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		rstn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		repeat (10) @(posedge core_clk);
		check(np_word, `NPT_RESET);
		check({15'h0000, np_send}, 16'h0000);
		rstn <= 1'b1;
		rd(`NPT_ADDR);
		check(rd_val, `NPT_RESET);
		foreach (rows[i])
		begin
			wr(`NPT_ADDR, rows[i][31:16]);
			check(np_word, rows[i][15:0]);
			rd(`NPT_ADDR);
			check(rd_val, rows[i][15:0]);
		end
		wr(5'h08, 16'hFFFF);
		rd(5'h08);
		check(rd_val, 16'h0000);
		rd(`NPT_ADDR);
		check(rd_val, 16'h87FF);
		wr(`NPT_ADDR, 16'h8001);
		link_partner_model_inst.pulse(1'b1, 1'b0, 1'b1);
		check({14'h0000, np_send, np_word.toggle}, 16'h0003);
		for (int i = 0; i < 2; i++)
		begin
			link_partner_model_inst.pulse(1'b0, 1'b0, 1'b1);
			check({15'h0000, np_word.toggle}, {15'h0000, i[0]});
		end
		rd(`NPT_ADDR);
		check(rd_val, 16'h8801);
		wr(`NPT_ADDR, 16'h0001);
		check({15'h0000, np_send}, 16'h0000);
		rd(`NPT_ADDR);
		check(rd_val, 16'h0801);
		link_partner_model_inst.pulse(1'b0, 1'b0, 1'b1);
		wr(`NPT_ADDR, 16'h8001);
		check({15'h0000, np_send}, 16'h0000);
		link_partner_model_inst.pulse(1'b1, 1'b0, 1'b0);
		check({14'h0000, np_send, np_word.toggle}, 16'h0001);
		@(posedge core_clk);
		rstn <= 1'b0;
		@(posedge core_clk);
		#1 check(np_word, `NPT_RESET);
		check({15'h0000, np_send}, 16'h0000);
		@(posedge core_clk);
		rstn <= 1'b1;
		rd(`NPT_ADDR);
		check(rd_val, `NPT_RESET);
		tally_and_finish;
	end
endmodule
